// >>> bsw_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants for the secondary status and window registers
// Assumes : 32-bit AXI4-Lite data, 12-bit byte address
// Notes   : registers decode on address bits 11:2
////////////////////////////////////////////////////////////////////////////////
package bsw_pkg;

    localparam int AXI_AW = 12;

    // register byte addresses
    localparam logic [11:0] ADDR_SEC_STATUS_IO = 12'h01C;
    localparam logic [11:0] ADDR_MEM_WINDOW    = 12'h020;
    localparam logic [11:0] ADDR_INT_STATUS    = 12'h040;
    localparam logic [11:0] ADDR_INT_MASK      = 12'h044;

    // field positions
    localparam int SIG_TA_BIT    = 27;
    localparam int MDP_BIT       = 24;
    localparam int IO_CEIL_LSB   = 12;
    localparam int IO_FLOOR_LSB  = 4;
    localparam int MEM_CEIL_LSB  = 20;
    localparam int MEM_FLOOR_LSB = 4;
    localparam int W1C_BYTE      = 3;

    // fixed read values
    localparam logic [1:0]  DEVSEL_MEDIUM  = 2'h1;
    localparam logic        FBB_CAPABLE    = 1'b1;
    localparam logic        M66_CAPABLE    = 1'b1;
    localparam logic [3:0]  IO_ADDR_CAP_32 = 4'h1;

    // reset values
    localparam logic [3:0]  IO_FIELD_RST  = 4'h0;
    localparam logic [11:0] MEM_FIELD_RST = 12'h000;
    localparam logic [1:0]  MASK_RST      = 2'h0;

    // low address bits implied by the window fields
    localparam logic [11:0] IO_LOW_ONES   = 12'hFFF;
    localparam logic [11:0] IO_LOW_ZERO   = 12'h000;
    localparam logic [19:0] MEM_LOW_ONES  = 20'hFFFFF;
    localparam logic [19:0] MEM_LOW_ZERO  = 20'h00000;

    // event bit indices, shared by status and interrupt registers
    localparam int EV_TA      = 0;
    localparam int EV_MDP     = 1;
    localparam int NUM_EVENTS = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_GOT_ADDR,
        WR_GOT_DATA,
        WR_RESP
    } bsw_wr_e;

endpackage : bsw_pkg

// >>> bsw_sticky_bits.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : vector of sticky event bits
// Assumes : set and clear are one-cycle requests
// Notes   : a set in the clearing cycle wins
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsw_sticky_bits
    import bsw_pkg::*;
#(
    parameter int N = 2
)
(
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [N-1:0] setBits,
    input  wire logic [N-1:0] clrBits,
    output logic      [N-1:0] bits
);

    typedef struct packed {
        logic [N-1:0] bits;
    } bsw_sticky_s;

    bsw_sticky_s state_r;
    bsw_sticky_s state_nxt;

    always_comb
    begin
        state_nxt      = state_r;
        state_nxt.bits = (state_r.bits & ~clrBits) | setBits;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign bits = state_r.bits;

endmodule : bsw_sticky_bits

// >>> bsw_range_match.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : inclusive window compare on an address segment
// Assumes : caller slices the segment and qualifies the lookup
// Notes   : answer is registered, one cycle after the lookup
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsw_range_match
    import bsw_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         lookupValid,
    input  wire logic [W-1:0] lookupSeg,
    input  wire logic [W-1:0] floorSeg,
    input  wire logic [W-1:0] ceilSeg,
    output logic              hit
);

    typedef struct packed {
        logic hit;
    } bsw_match_s;

    bsw_match_s state_r;
    bsw_match_s state_nxt;

    // an inverted window can never satisfy both compares
    always_comb
    begin
        state_nxt     = state_r;
        state_nxt.hit = lookupValid && (lookupSeg >= floorSeg) && (lookupSeg <= ceilSeg);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign hit = state_r.hit;

endmodule : bsw_range_match

// >>> bsw_regs.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : secondary status, I/O window and memory window registers of a bridge
// Assumes : AXI4-Lite slave, one clock, synchronous active-low reset
// Notes   : window lookups answer one cycle later; irq lags status by one cycle
// Notes on behaviour
// - target-abort signalled on secondary bus sets bit 27; write one clears it
// - device-select timing bits 26:25 always read medium speed, writes ignored
// - uncorrectable secondary data error sets bit 24; write one clears it
// - fast back-to-back capable bit 23 always reads one
// - 66 MHz capable bit 21 always reads one
// - I/O ceiling gives address bits 15:12, low twelve bits all ones
// - I/O floor gives address bits 15:12, low twelve bits zero
// - I/O transactions inside the I/O window are forwarded
// - both I/O addressing capability fields read 1, meaning 32-bit I/O
// - memory ceiling gives address bits 31:20, low twenty bits all ones, resets zero
// - memory floor gives address bits 31:20, low twenty bits zero, resets zero
// - memory transactions inside the memory window are forwarded
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bsw_regs
    import bsw_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // AXI4-Lite write address
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // secondary bus events
    input  wire logic              targetAbortSignaled,
    input  wire logic              masterDataParityErrorEvent,
    // I/O window lookup
    input  wire logic              ioLookupValid,
    input  wire logic [31:0]       ioLookupAddr,
    output logic                   ioForward,
    // memory window lookup
    input  wire logic              memLookupValid,
    input  wire logic [31:0]       memLookupAddr,
    output logic                   memForward,
    // decoded window bounds
    output logic [31:0]            ioWindowFloorAddr,
    output logic [31:0]            ioWindowCeilingAddr,
    output logic [31:0]            memWindowFloorAddr,
    output logic [31:0]            memWindowCeilingAddr,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        bsw_wr_e     wrState;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [3:0]  ioWindowCeiling;
        logic [3:0]  ioWindowFloor;
        logic [11:0] memoryWindowCeiling;
        logic [11:0] memoryWindowFloor;
        logic [1:0]  irqMask;
        logic        irq;
    } bsw_regs_s;

    bsw_regs_s state_r;
    bsw_regs_s state_nxt;

    logic                  awFire;
    logic                  wFire;
    logic                  arFire;
    logic [NUM_EVENTS-1:0] eventBits;
    logic [NUM_EVENTS-1:0] statusBits;
    logic [NUM_EVENTS-1:0] intStatus;
    logic [NUM_EVENTS-1:0] w1cBits;
    logic [NUM_EVENTS-1:0] readClr;
    logic [31:0]           secStatusWord;
    logic [31:0]           memWindowWord;
    logic                  ioLookupQual;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] applyStrb(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0]  strb
    );
        logic [31:0] merged;
        merged = oldWord;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                merged[b*8 +: 8] = newWord[b*8 +: 8];
        end
        return merged;
    endfunction : applyStrb

    function automatic logic sameReg(
        input logic [11:0] a,
        input logic [11:0] b
    );
        return a[11:2] == b[11:2];
    endfunction : sameReg

    ////////////////////////////////////////////////////////////////////////////
    // register images

    // bits 31:28 belong to status outside this block and read zero here
    assign secStatusWord = {
        4'h0,
        statusBits[EV_TA],
        DEVSEL_MEDIUM,
        statusBits[EV_MDP],
        FBB_CAPABLE,
        1'b0,
        M66_CAPABLE,
        5'h00,
        state_r.ioWindowCeiling,
        IO_ADDR_CAP_32,
        state_r.ioWindowFloor,
        IO_ADDR_CAP_32
    };

    assign memWindowWord = {
        state_r.memoryWindowCeiling,
        4'h0,
        state_r.memoryWindowFloor,
        4'h0
    };

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes

    assign s_axi_awready = (state_r.wrState == WR_IDLE) || (state_r.wrState == WR_GOT_DATA);
    assign s_axi_wready  = (state_r.wrState == WR_IDLE) || (state_r.wrState == WR_GOT_ADDR);
    assign s_axi_bvalid  = (state_r.wrState == WR_RESP);
    assign s_axi_bresp   = state_r.bResp;
    assign s_axi_arready = !state_r.rValid;
    assign s_axi_rvalid  = state_r.rValid;
    assign s_axi_rdata   = state_r.rData;
    assign s_axi_rresp   = state_r.rResp;

    assign awFire = s_axi_awvalid && s_axi_awready;
    assign wFire  = s_axi_wvalid && s_axi_wready;
    assign arFire = s_axi_arvalid && s_axi_arready;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [11:0] effAddr;
        logic [31:0] effData;
        logic [3:0]  effStrb;
        logic [31:0] word;
        logic        doWrite;

        state_nxt = state_r;
        w1cBits   = '0;
        readClr   = '0;
        effAddr   = awFire ? s_axi_awaddr : state_r.awAddr;
        effData   = wFire ? s_axi_wdata : state_r.wData;
        effStrb   = wFire ? s_axi_wstrb : state_r.wStrb;
        word      = 32'h0000_0000;
        doWrite   = 1'b0;

        state_nxt.awAddr = effAddr;
        state_nxt.wData  = effData;
        state_nxt.wStrb  = effStrb;

        // address and data may arrive in either order
        case (state_r.wrState)
            WR_IDLE:
            begin
                if (awFire && wFire)
                    doWrite = 1'b1;
                else if (awFire)
                    state_nxt.wrState = WR_GOT_ADDR;
                else if (wFire)
                    state_nxt.wrState = WR_GOT_DATA;
            end
            WR_GOT_ADDR:
            begin
                if (wFire)
                    doWrite = 1'b1;
            end
            WR_GOT_DATA:
            begin
                if (awFire)
                    doWrite = 1'b1;
            end
            WR_RESP:
            begin
                if (s_axi_bready)
                    state_nxt.wrState = WR_IDLE;
            end
            default:
            begin
                state_nxt.wrState = WR_IDLE;
            end
        endcase

        if (doWrite)
        begin
            state_nxt.wrState = WR_RESP;
            state_nxt.bResp   = RESP_OKAY;
            if (sameReg(effAddr, ADDR_SEC_STATUS_IO))
            begin
                word = applyStrb(secStatusWord, effData, effStrb);
                state_nxt.ioWindowCeiling = word[IO_CEIL_LSB +: 4];
                state_nxt.ioWindowFloor   = word[IO_FLOOR_LSB +: 4];
                // read-only fields come back from constants, so writes vanish
                w1cBits[EV_TA]  = effStrb[W1C_BYTE] && effData[SIG_TA_BIT];
                w1cBits[EV_MDP] = effStrb[W1C_BYTE] && effData[MDP_BIT];
            end
            else if (sameReg(effAddr, ADDR_MEM_WINDOW))
            begin
                word = applyStrb(memWindowWord, effData, effStrb);
                state_nxt.memoryWindowCeiling = word[MEM_CEIL_LSB +: 12];
                state_nxt.memoryWindowFloor   = word[MEM_FLOOR_LSB +: 12];
            end
            else if (sameReg(effAddr, ADDR_INT_MASK))
            begin
                word = applyStrb({30'h0, state_r.irqMask}, effData, effStrb);
                state_nxt.irqMask = word[NUM_EVENTS-1:0];
            end
            else if (sameReg(effAddr, ADDR_INT_STATUS))
            begin
                // status clears only by reading; a write is accepted and dropped
            end
            else
            begin
                state_nxt.bResp = RESP_DECERR;
            end
        end

        // read channel: one outstanding read, data held until rready
        if (state_r.rValid && s_axi_rready)
            state_nxt.rValid = 1'b0;

        if (arFire)
        begin
            state_nxt.rValid = 1'b1;
            state_nxt.rResp  = RESP_OKAY;
            if (sameReg(s_axi_araddr, ADDR_SEC_STATUS_IO))
                state_nxt.rData = secStatusWord;
            else if (sameReg(s_axi_araddr, ADDR_MEM_WINDOW))
                state_nxt.rData = memWindowWord;
            else if (sameReg(s_axi_araddr, ADDR_INT_MASK))
                state_nxt.rData = {30'h0, state_r.irqMask};
            else if (sameReg(s_axi_araddr, ADDR_INT_STATUS))
            begin
                state_nxt.rData = {30'h0, intStatus};
                // only the bits returned are cleared; a fresh event still lands
                readClr = intStatus;
            end
            else
            begin
                state_nxt.rData = 32'h0000_0000;
                state_nxt.rResp = RESP_DECERR;
            end
        end

        state_nxt.irq = |(intStatus & state_r.irqMask);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_r                     <= '0;
            state_r.ioWindowCeiling     <= IO_FIELD_RST;
            state_r.ioWindowFloor       <= IO_FIELD_RST;
            state_r.memoryWindowCeiling <= MEM_FIELD_RST;
            state_r.memoryWindowFloor   <= MEM_FIELD_RST;
            state_r.irqMask             <= MASK_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event capture

    assign eventBits[EV_TA]  = targetAbortSignaled;
    assign eventBits[EV_MDP] = masterDataParityErrorEvent;

    // write-one-to-clear view seen in the status register
    bsw_sticky_bits #(
        .N       (NUM_EVENTS)
    ) u_status_bits (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .setBits (eventBits),
        .clrBits (w1cBits),
        .bits    (statusBits)
    );

    // read-to-clear view that drives the interrupt
    bsw_sticky_bits #(
        .N       (NUM_EVENTS)
    ) u_int_bits (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .setBits (eventBits),
        .clrBits (readClr),
        .bits    (intStatus)
    );

    assign irq = state_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // window decode

    // upper I/O address half is taken as zero, so only 16-bit I/O hits
    assign ioLookupQual = ioLookupValid && (ioLookupAddr[31:16] == 16'h0000);

    bsw_range_match #(
        .W           (4)
    ) u_io_match (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .lookupValid (ioLookupQual),
        .lookupSeg   (ioLookupAddr[15:12]),
        .floorSeg    (state_r.ioWindowFloor),
        .ceilSeg     (state_r.ioWindowCeiling),
        .hit         (ioForward)
    );

    bsw_range_match #(
        .W           (12)
    ) u_mem_match (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .lookupValid (memLookupValid),
        .lookupSeg   (memLookupAddr[31:20]),
        .floorSeg    (state_r.memoryWindowFloor),
        .ceilSeg     (state_r.memoryWindowCeiling),
        .hit         (memForward)
    );

    assign ioWindowFloorAddr    = {16'h0000, state_r.ioWindowFloor, IO_LOW_ZERO};
    assign ioWindowCeilingAddr  = {16'h0000, state_r.ioWindowCeiling, IO_LOW_ONES};
    assign memWindowFloorAddr   = {state_r.memoryWindowFloor, MEM_LOW_ZERO};
    assign memWindowCeilingAddr = {state_r.memoryWindowCeiling, MEM_LOW_ONES};

endmodule : bsw_regs

// >>> bsw_regs_sva.sv
// Purpose: port checks for bsw_regs
// Assumes: one clock, synchronous active-low reset
// Notes: read address is kept to judge the word returned
`timescale 1ns/1ps
module bsw_regs_sva
    import bsw_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              ioLookupValid,
    input wire logic [31:0]       ioLookupAddr,
    input wire logic              ioForward,
    input wire logic              memLookupValid,
    input wire logic [31:0]       memLookupAddr,
    input wire logic              memForward,
    input wire logic [31:0]       ioWindowFloorAddr,
    input wire logic [31:0]       ioWindowCeilingAddr,
    input wire logic [31:0]       memWindowFloorAddr,
    input wire logic [31:0]       memWindowCeilingAddr,
    input wire logic              irq
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!resetn);
////////////////////////////////////////
logic [11:0] rdAddr_r;
logic        ioIn;
logic        memIn;
logic        secRd;
logic        memRd;
// upper I/O bits outside the window make ioIn false on their own
assign ioIn = ioLookupValid && ioLookupAddr >= ioWindowFloorAddr && ioLookupAddr <= ioWindowCeilingAddr;
assign memIn = memLookupValid && memLookupAddr >= memWindowFloorAddr && memLookupAddr <= memWindowCeilingAddr;
assign secRd = s_axi_rvalid && rdAddr_r[11:2] == ADDR_SEC_STATUS_IO[11:2];
assign memRd = s_axi_rvalid && rdAddr_r[11:2] == ADDR_MEM_WINDOW[11:2];
always_ff @(posedge sys_clk)
begin
    if (s_axi_arvalid && s_axi_arready)
    begin
        rdAddr_r <= s_axi_araddr;
    end
end
////////////////////////////////////////
AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write taken without response");
AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read taken without data");
AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
AST_SEC_FIXED: assert property (secRd |-> s_axi_rdata[26:25] == DEVSEL_MEDIUM && s_axi_rdata[23]
    && s_axi_rdata[21] && s_axi_rdata[11:8] == IO_ADDR_CAP_32 && s_axi_rdata[3:0] == IO_ADDR_CAP_32)
    else $error("fixed status fields wrong");
AST_SEC_RSVD: assert property (secRd |-> s_axi_rdata[22] == 1'b0 && s_axi_rdata[20:16] == 5'h00)
    else $error("status reserved bits set");
AST_MEM_RSVD: assert property (memRd |-> s_axi_rdata[19:16] == 4'h0 && s_axi_rdata[3:0] == 4'h0)
    else $error("memory reserved bits set");
AST_IO_FWD: assert property (1'b1 |=> ioForward == $past(ioIn))
    else $error("io forward wrong");
AST_MEM_FWD: assert property (1'b1 |=> memForward == $past(memIn))
    else $error("memory forward wrong");
AST_BOUNDS: assert property (ioWindowFloorAddr[11:0] == IO_LOW_ZERO && ioWindowCeilingAddr[11:0] == IO_LOW_ONES
    && memWindowFloorAddr[19:0] == MEM_LOW_ZERO && memWindowCeilingAddr[19:0] == MEM_LOW_ONES)
    else $error("window low bits wrong");
COV_WR: cover property (s_axi_bvalid);
COV_IO: cover property (ioForward);
COV_IRQ: cover property ($rose(irq));
endmodule : bsw_regs_sva

bind bsw_regs bsw_regs_sva chk (.*);

// >>> bsw_sec_agent.sv
// Purpose: secondary bus agent raising events and window lookups
// Assumes: driven after rising edges only
// Notes: a released address shows its inverse, never the old value
`timescale 1ns/1ps
module bsw_sec_agent
(
    input  wire logic sys_clk,
    input  wire logic ioForward,
    input  wire logic memForward,
    output logic      targetAbortSignaled,
    output logic      masterDataParityErrorEvent,
    output logic      ioLookupValid,
    output logic [31:0] ioLookupAddr,
    output logic      memLookupValid,
    output logic [31:0] memLookupAddr
);
initial
begin
    targetAbortSignaled = 1'b0;
    masterDataParityErrorEvent = 1'b0;
    ioLookupValid = 1'b0;
    ioLookupAddr = 32'h0;
    memLookupValid = 1'b0;
    memLookupAddr = 32'h0;
end
task automatic pulse(input logic mdp);
    @(posedge sys_clk);
    targetAbortSignaled <= !mdp;
    masterDataParityErrorEvent <= mdp;
    @(posedge sys_clk);
    targetAbortSignaled <= 1'b0;
    masterDataParityErrorEvent <= 1'b0;
endtask : pulse
task automatic look(input logic mem, input logic [31:0] a, output logic hit);
    @(posedge sys_clk);
    ioLookupValid <= !mem;
    memLookupValid <= mem;
    ioLookupAddr <= a;
    memLookupAddr <= a;
    @(posedge sys_clk);
    ioLookupValid <= 1'b0;
    memLookupValid <= 1'b0;
    ioLookupAddr <= ~a;
    memLookupAddr <= ~a;
    #1;
    hit = mem ? memForward : ioForward;
endtask : look
endmodule : bsw_sec_agent

// >>> bsw_regs_tb_top.sv
// Purpose: register, event and window tests for bsw_regs
// Assumes: every bus answer within 50 cycles
// Notes: lookups and events come from the agent model
`timescale 1ns/1ps
module bsw_regs_tb_top
    import bsw_pkg::*;
;
logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0, s_axi_rdata, ioLookupAddr, memLookupAddr, rd;
logic [31:0] ioWindowFloorAddr, ioWindowCeilingAddr, memWindowFloorAddr, memWindowCeilingAddr;
logic [3:0] s_axi_wstrb = '0;
logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
logic sys_clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
logic s_axi_arready, s_axi_rvalid, irq, hit, ioForward, memForward;
logic targetAbortSignaled, masterDataParityErrorEvent, ioLookupValid, memLookupValid;
int errTotal = 0;
int samplesChecked = 0;
// {memory, hit, address}; I/O window 3..5, memory window 120..123
localparam logic [33:0] LOOKS [9] = '{{2'b00, 32'h2FFF}, {2'b01, 32'h3000}, {2'b01, 32'h5FFF},
    {2'b00, 32'h6000}, {2'b00, 32'h1_4000}, {2'b10, 32'h11FF_FFFF}, {2'b11, 32'h1200_0000},
    {2'b11, 32'h123F_FFFF}, {2'b10, 32'h1240_0000}};
always #5 sys_clk = ~sys_clk;
bsw_regs uut (.*);
bsw_sec_agent sec (.sys_clk, .ioForward, .memForward, .targetAbortSignaled, .masterDataParityErrorEvent,
    .ioLookupValid, .ioLookupAddr, .memLookupValid, .memLookupAddr);
////////////////////////////////////////
task automatic endSim;
    if (errTotal == 0 && samplesChecked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask : endSim
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
        errTotal++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask : check
task automatic waitStep(input int n);
    if (n > 50)
    begin
        errTotal++;
        endSim();
    end
endtask : waitStep
task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
        @(posedge sys_clk);
        n++;
        waitStep(n);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask : axiWr
task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
        @(posedge sys_clk);
        n++;
        waitStep(n);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask : axiRd
task automatic wrChk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axiWr(a, d, s, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
endtask : wrChk
task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, RESP_OKAY});
endtask : rdChk
////////////////////////////////////////
initial
begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rdChk(ADDR_SEC_STATUS_IO, 32'h02A0_0101);
    rdChk(ADDR_MEM_WINDOW, 32'h0000_0000);
    wrChk(ADDR_SEC_STATUS_IO, 32'hFFFF_FFFF, 4'hF);
    rdChk(ADDR_SEC_STATUS_IO, 32'h02A0_F1F1);
    wrChk(ADDR_MEM_WINDOW, 32'hFFFF_FFFF, 4'hF);
    rdChk(ADDR_MEM_WINDOW, 32'hFFF0_FFF0);
    wrChk(ADDR_MEM_WINDOW, 32'h0000_0000, 4'h3);
    rdChk(ADDR_MEM_WINDOW, 32'hFFF0_0000);
    check(memWindowCeilingAddr, 32'hFFFF_FFFF);
    wrChk(ADDR_MEM_WINDOW, 32'h1230_1200, 4'hF);
    check(memWindowFloorAddr, 32'h1200_0000);
    wrChk(ADDR_SEC_STATUS_IO, 32'h0000_5030, 4'hF);
    check(ioWindowCeilingAddr, 32'h0000_5FFF);
    check(ioWindowFloorAddr, 32'h0000_3000);
    foreach (LOOKS[i])
    begin
        sec.look(LOOKS[i][33], LOOKS[i][31:0], hit);
        check({31'h0, hit}, {31'h0, LOOKS[i][32]});
    end
    // floor above ceiling closes the window
    wrChk(ADDR_SEC_STATUS_IO, 32'h0000_5060, 4'hF);
    sec.look(1'b0, 32'h0000_5000, hit);
    check({31'h0, hit}, 32'h0);
    wrChk(ADDR_INT_MASK, 32'h0000_0003, 4'hF);
    sec.pulse(1'b0);
    sec.pulse(1'b1);
    repeat (2) @(posedge sys_clk);
    #1;
    check({31'h0, irq}, 32'h1);
    rdChk(ADDR_SEC_STATUS_IO, 32'h0BA0_5161);
    rdChk(ADDR_INT_STATUS, 32'h0000_0003);
    rdChk(ADDR_INT_STATUS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    wrChk(ADDR_SEC_STATUS_IO, 32'h0800_5060, 4'hF);
    rdChk(ADDR_SEC_STATUS_IO, 32'h03A0_5161);
    wrChk(ADDR_SEC_STATUS_IO, 32'h0100_5060, 4'hF);
    rdChk(ADDR_SEC_STATUS_IO, 32'h02A0_5161);
    wrChk(ADDR_INT_MASK, 32'h0000_0000, 4'hF);
    sec.pulse(1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    check({31'h0, irq}, 32'h0);
    rdChk(ADDR_INT_STATUS, 32'h0000_0001);
    axiRd(12'h100, rd, rsp);
    check(rd, 32'h0);
    check({30'h0, rsp}, {30'h0, RESP_DECERR});
    axiWr(12'h104, 32'hFFFF_FFFF, 4'hF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_DECERR});
    endSim();
end
endmodule : bsw_regs_tb_top
